// [rtl/vtc_datapath.sv]
// Voltage and temperature channel datapath of the metering core.
// Assumes samples from the remote converters arrive as one strobe per
// 8 kSPS period carrying all four lines, more than 1000 cycles apart.
//
// Contract
// - Each voltage result is a signed 24-bit word, one per channel at 8 kSPS.
// - Full scale nominally spans about plus and minus 5,320,000 codes.
// - Four select bits reset to one and drive their select pins high.
// - A cleared select bit drives its select pin low for temperature.
// - Remote chips without second input always deliver temperature.
// - Factory temperature offset from the link stored per line, 8-bit signed.
// - Temperature offset is shifted left 11 bits before being added.
// - Temperature samples scale by one plus gain over two to the 23.
// - Temperature results written 1.024 s after select low, then each sample.
// - Temperature results read as 32 bits with top eight bits zero.
// - Each voltage channel scales by one plus gain over two to the 23.
// - Voltage gain affects all downstream results including waveforms.
// - Gains read sign-extended to 28 bits with the top four bits zero.
// - Config bit 4 enables or bypasses all high-pass filters together.
// - High-pass output captured into waveform registers at 8 kSPS.
// - New waveforms set status bit 17; mask bit 17 raises the interrupt.
// - Pin function 00: pin low 6.5 us before ready flag, low 10 us.
// - Pin function 01, 10, 11 carries zero-crossing level instead.
// - Waveform registers read sign-extended to 32 bits.
// - Filter enable reads one after reset.
//
// Register access over AXI4-Lite and the address map were decided locally.
`include "vtc_map.svh"
`timescale 1ns/10ps
`default_nettype none
module vtc_datapath #(
  parameter int SETTLE_CYCLES = `VTC_SETTLE_MS * 100000
) (
  // Clock and reset.
  input  wire logic             aclk,
  input  wire logic             aresetn,
  // AXI4-Lite register slave.
  input  wire logic [7:0]       s_axi_awaddr,
  input  wire logic             s_axi_awvalid,
  output var  logic             s_axi_awready,
  input  wire logic [31:0]      s_axi_wdata,
  input  wire logic [3:0]       s_axi_wstrb,
  input  wire logic             s_axi_wvalid,
  output var  logic             s_axi_wready,
  output var  logic [1:0]       s_axi_bresp,
  output var  logic             s_axi_bvalid,
  input  wire logic             s_axi_bready,
  input  wire logic [7:0]       s_axi_araddr,
  input  wire logic             s_axi_arvalid,
  output var  logic             s_axi_arready,
  output var  logic [31:0]      s_axi_rdata,
  output var  logic [1:0]       s_axi_rresp,
  output var  logic             s_axi_rvalid,
  input  wire logic             s_axi_rready,
  // Samples and offsets from the remote converters.
  input  wire logic             sample_valid,
  input  wire vtc_pkg::vtc_line_t line_sample [4],
  input  wire vtc_pkg::vtc_off_t  offset_load,
  // Zero-crossing levels of phases A, B and C.
  input  wire logic [2:0]       zx_phase_level,
  // Pins.
  output var  logic             phase_a_select_pin,
  output var  logic             phase_b_select_pin,
  output var  logic             phase_c_select_pin,
  output var  logic             neutral_select_pin,
  output var  logic             shared_event_pin,
  output var  logic             irq_n
);
  import vtc_pkg::*;

  localparam int DR_LEAD = (`VTC_DR_LEAD_NS + `VTC_CLK_NS - 1) / `VTC_CLK_NS;
  localparam int DR_LOW = (`VTC_DR_LOW_NS + `VTC_CLK_NS - 1) / `VTC_CLK_NS;
  localparam int SW = $clog2(SETTLE_CYCLES + 1);

  ////////////////////////////////////////////////////////////////////////////
  // Registers.
  logic [15:0]        config_q;
  logic [3:0]         config_reg_three_q;
  logic               sample_ready_flag_q;
  logic               mask_rdy_q;
  logic signed [23:0] vgain_q [8];
  logic signed [23:0] tgain_q [4];
  logic signed [7:0]  toff_q [4];
  logic signed [23:0] wave_q [8];
  logic signed [23:0] temp_q [4];
  logic signed [23:0] hp_q [8];
  logic signed [23:0] traw_q [4];
  logic signed [31:0] dc_q [8];
  logic [SW-1:0]      settle_q [4];
  logic [3:0]         sel_q;
  vtc_rdy_state_t     rdy_q;
  logic [9:0]         rdy_cnt_q;
  logic               aw_got_q, w_got_q;
  logic [7:0]         awaddr_q;
  logic [31:0]        wdata_q;
  logic [3:0]         wstrb_q;
  logic               wr_fire, capture;
  logic [31:0]        rd_d;
  logic               rd_err;

  // Signed 24-bit multiply by (1 + g / 2^23), saturating at the rails.
  // Full-scale codes of about 5.32 million stay clear of them.
  function automatic logic signed [23:0] scale(input logic signed [23:0] x,
                                               input logic signed [23:0] g);
    logic signed [47:0] p;
    logic signed [25:0] s;
    p = x * g;
    s = 26'(x) + 26'(p >>> `VTC_GAIN_FRAC);
    if (s > 26'sh07fffff) begin
      scale = 24'sh7fffff;
    end else if (s < -26'sh0800000) begin
      scale = -24'sh800000;
    end else begin
      scale = s[23:0];
    end
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] o,
                                        input logic [31:0] n,
                                        input logic [3:0] b);
    for (int i = 0; i < 4; i++) begin
      merge[i*8 +: 8] = b[i] ? n[i*8 +: 8] : o[i*8 +: 8];
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Write channel: address and data are taken in either order.
  assign wr_fire = aw_got_q & w_got_q & ~s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end else begin
      s_axi_awready <= ~aw_got_q & ~(s_axi_awvalid & s_axi_awready);
      s_axi_wready <= ~w_got_q & ~(s_axi_wvalid & s_axi_wready);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awaddr_q >= `VTC_OFF_TOFF) ? 2'h2 : 2'h0;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_got_q <= 1'b0;
        w_got_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      config_q <= `VTC_CFG_RST;
      config_reg_three_q <= `VTC_CFG3_RST;
      mask_rdy_q <= 1'b0;
      for (int i = 0; i < 8; i++) vgain_q[i] <= 24'sh000000;
      for (int i = 0; i < 4; i++) tgain_q[i] <= 24'sh000000;
    end else if (wr_fire) begin
      if (awaddr_q[7:2] == `VTC_OFF_CONFIG >> 2) begin
        config_q <= 16'(merge({16'h0, config_q}, wdata_q, wstrb_q));
      end else if (awaddr_q[7:2] == `VTC_OFF_CONFIG_REG_THREE >> 2) begin
        config_reg_three_q <= 4'(merge({28'h0, config_reg_three_q},
                                       wdata_q, wstrb_q));
      end else if (awaddr_q[7:2] == `VTC_OFF_IRQ_MASK_ZERO >> 2) begin
        mask_rdy_q <= wstrb_q[2] ? wdata_q[`VTC_RDY_BIT] : mask_rdy_q;
      end else if (awaddr_q >= `VTC_OFF_VGAIN && awaddr_q < `VTC_OFF_TGAIN) begin
        // The gain block starts at 0x10, so offset bit 4 is flipped.
        vgain_q[awaddr_q[4:2] ^ 3'h4] <=
          24'(merge({8'h0, vgain_q[awaddr_q[4:2] ^ 3'h4]}, wdata_q, wstrb_q));
      end else if (awaddr_q >= `VTC_OFF_TGAIN && awaddr_q < `VTC_OFF_TOFF) begin
        tgain_q[awaddr_q[3:2]] <= 24'(merge({8'h0, tgain_q[awaddr_q[3:2]]},
                                           wdata_q, wstrb_q));
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read channel, answered one cycle after the address is taken.
  always_comb begin
    rd_d = 32'h0000_0000;
    rd_err = 1'b0;
    if (s_axi_araddr[7:2] == `VTC_OFF_CONFIG >> 2) begin
      rd_d = {16'h0, config_q};
    end else if (s_axi_araddr[7:2] == `VTC_OFF_CONFIG_REG_THREE >> 2) begin
      rd_d = {28'h0, config_reg_three_q};
    end else if (s_axi_araddr[7:2] == `VTC_OFF_STATUS_REG_ZERO >> 2) begin
      rd_d[`VTC_RDY_BIT] = sample_ready_flag_q;
    end else if (s_axi_araddr[7:2] == `VTC_OFF_IRQ_MASK_ZERO >> 2) begin
      rd_d[`VTC_RDY_BIT] = mask_rdy_q;
    end else if (s_axi_araddr < `VTC_OFF_TGAIN) begin
      rd_d = {4'h0, {4{vgain_q[s_axi_araddr[4:2] ^ 3'h4][23]}},
              vgain_q[s_axi_araddr[4:2] ^ 3'h4]};
    end else if (s_axi_araddr < `VTC_OFF_TOFF) begin
      rd_d = {4'h0, {4{tgain_q[s_axi_araddr[3:2]][23]}},
              tgain_q[s_axi_araddr[3:2]]};
    end else if (s_axi_araddr < `VTC_OFF_WAVE) begin
      rd_d = 32'(toff_q[s_axi_araddr[3:2]]);
    end else if (s_axi_araddr < `VTC_OFF_TEMP) begin
      rd_d = 32'(wave_q[s_axi_araddr[4:2] ^ 3'h4]);
    end else if (s_axi_araddr < `VTC_OFF_END) begin
      rd_d = {8'h00, temp_q[s_axi_araddr[3:2]]};
    end else begin
      rd_err = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_d;
      s_axi_rresp <= rd_err ? 2'h2 : 2'h0;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end else begin
      s_axi_arready <= ~s_axi_rvalid;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Select pins, settle timers and factory offsets.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sel_q <= `VTC_CFG3_RST;
      for (int i = 0; i < 4; i++) settle_q[i] <= '0;
    end else begin
      sel_q <= config_reg_three_q;
      // Chips lacking the second input are timed the same way.
      for (int i = 0; i < 4; i++) begin
        if (sel_q[i]) begin
          settle_q[i] <= '0;
        end else if (settle_q[i] != SW'(SETTLE_CYCLES)) begin
          settle_q[i] <= settle_q[i] + SW'(1);
        end
      end
    end
  end
  assign phase_a_select_pin = sel_q[0];
  assign phase_b_select_pin = sel_q[1];
  assign phase_c_select_pin = sel_q[2];
  assign neutral_select_pin = sel_q[3];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < 4; i++) toff_q[i] <= 8'sh00;
    end else if (offset_load.valid) begin
      toff_q[offset_load.line] <= offset_load.value;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sample processing: gain, then the per-channel high-pass filter.
  // The filter tracks the dc level in a 32-bit accumulator with 8 fraction
  // bits, so that small offsets are removed without a dead zone.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < 8; i++) begin
        hp_q[i] <= 24'sh000000;
        dc_q[i] <= 32'sh0;
      end
      for (int i = 0; i < 4; i++) traw_q[i] <= 24'sh000000;
    end else if (sample_valid) begin
      for (int i = 0; i < 8; i++) begin
        automatic logic signed [23:0] x = i[0] ? line_sample[i/2].sec
                                               : line_sample[i/2].prim;
        automatic logic signed [23:0] s = scale(x, vgain_q[i]);
        automatic logic signed [31:0] e = (32'(s) <<< 8) - dc_q[i];
        dc_q[i] <= dc_q[i] + (e >>> `VTC_HPF_SHIFT);
        // One bit bypasses every filter.
        hp_q[i] <= config_q[`VTC_CFG_HPF_BIT] ?
                   24'(s - 24'(dc_q[i] >>> 8)) : s;
      end
      for (int i = 0; i < 4; i++) begin
        traw_q[i] <= scale(line_sample[i].sec
                           + {{5{toff_q[i][7]}}, toff_q[i],
                              11'h000}, tgain_q[i]);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Data-ready sequence: pin falls with the sample, flag follows 6.5 us on.
  assign capture = (rdy_q == VTC_LEAD) && (rdy_cnt_q == 10'(DR_LEAD - 1));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rdy_q <= VTC_IDLE;
      rdy_cnt_q <= 10'h000;
    end else begin
      case (rdy_q)
        VTC_IDLE: begin
          rdy_cnt_q <= 10'h000;
          if (sample_valid) begin
            rdy_q <= VTC_LEAD;
          end
        end
        VTC_LEAD: begin
          rdy_cnt_q <= rdy_cnt_q + 10'h001;
          if (capture) begin
            rdy_q <= VTC_TAIL;
          end
        end
        VTC_TAIL: begin
          rdy_cnt_q <= rdy_cnt_q + 10'h001;
          if (rdy_cnt_q == 10'(DR_LOW - 1)) begin
            rdy_q <= VTC_IDLE;
          end
        end
        default: rdy_q <= VTC_IDLE;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < 8; i++) wave_q[i] <= 24'sh000000;
      for (int i = 0; i < 4; i++) temp_q[i] <= 24'sh000000;
    end else if (capture) begin
      for (int i = 0; i < 8; i++) wave_q[i] <= hp_q[i];
      for (int i = 0; i < 4; i++) begin
        if (settle_q[i] == SW'(SETTLE_CYCLES)) begin
          temp_q[i] <= traw_q[i];
        end
      end
    end
  end

  // A new capture in the clearing cycle keeps the flag set.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sample_ready_flag_q <= 1'b0;
      irq_n <= 1'b1;
      shared_event_pin <= 1'b1;
    end else begin
      sample_ready_flag_q <= capture | (sample_ready_flag_q & ~(wr_fire
        && awaddr_q[7:2] == `VTC_OFF_STATUS_REG_ZERO >> 2 && wstrb_q[2]
        && wdata_q[`VTC_RDY_BIT]));
      irq_n <= ~(sample_ready_flag_q & mask_rdy_q);
      if (config_q[1:0] == 2'b00) begin
        // The pin rises in the last counted cycle, so it is low 10 us.
        shared_event_pin <= (rdy_q == VTC_IDLE
                             || (rdy_q == VTC_TAIL
                                 && rdy_cnt_q == 10'(DR_LOW - 1)))
                            && !sample_valid;
      end else begin
        shared_event_pin <= zx_phase_level[config_q[1:0] - 2'b01];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  sel_follow_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ##1 phase_a_select_pin == $past(config_reg_three_q[0]))
    else $error("select pin does not follow its enable bit");
  ready_lead_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(sample_ready_flag_q) |-> rdy_cnt_q == 10'(DR_LEAD))
    else $error("ready flag not 6.5 us after the pin fell");
  pin_low_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(shared_event_pin) && config_q[1:0] == 2'b00
      && $past(config_q[1:0]) == 2'b00 |-> $past(rdy_cnt_q) == 10'(DR_LOW - 1))
    else $error("ready pin low time is not 10 us");
  hpf_reset_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !$past(aresetn) |-> config_q[`VTC_CFG_HPF_BIT] && config_reg_three_q == 4'hf)
    else $error("filter or select enable wrong after reset");
  temp_settle_a: assert property (@(posedge aclk) disable iff (!aresetn)
    temp_q[0] != $past(temp_q[0]) |-> $past(settle_q[0]) == SW'(SETTLE_CYCLES))
    else $error("temperature written before settling");
  irq_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
    sample_ready_flag_q && mask_rdy_q |=> !irq_n ##1 (irq_n || mask_rdy_q))
    else $error("masked ready event did not raise the interrupt");
  set_wins_a: assert property (@(posedge aclk) disable iff (!aresetn)
    capture |=> sample_ready_flag_q && wave_q[0] == $past(hp_q[0]))
    else $error("capture lost its flag or sample");
  offset_store_a: assert property (@(posedge aclk) disable iff (!aresetn)
    offset_load.valid |=> toff_q[$past(offset_load.line)] == $past(offset_load.value))
    else $error("factory offset not stored");
  cover_ready_c: cover property (@(posedge aclk) disable iff (!aresetn)
    $rose(sample_ready_flag_q));
  cover_temp_c: cover property (@(posedge aclk) disable iff (!aresetn)
    capture && settle_q[0] == SW'(SETTLE_CYCLES));
  cover_zx_c: cover property (@(posedge aclk) disable iff (!aresetn)
    config_q[1:0] == 2'b10 && $fell(shared_event_pin));
endmodule
`default_nettype wire

// [rtl/vtc_map.svh]
// Constants of the voltage and temperature channel datapath: register
// offsets, field positions, reset values and timing figures.
// Assumes a 100 MHz aclk and a 32-bit register bus.
`ifndef VTC_MAP_SVH
`define VTC_MAP_SVH
`define VTC_OFF_CONFIG   8'h00
`define VTC_OFF_CONFIG_REG_THREE  8'h04
`define VTC_OFF_STATUS_REG_ZERO  8'h08
`define VTC_OFF_IRQ_MASK_ZERO    8'h0c
`define VTC_OFF_VGAIN    8'h10
`define VTC_OFF_TGAIN    8'h30
`define VTC_OFF_TOFF     8'h40
`define VTC_OFF_WAVE     8'h50
`define VTC_OFF_TEMP     8'h70
`define VTC_OFF_END      8'h80
`define VTC_CFG_HPF_BIT  4
`define VTC_RDY_BIT      17
`define VTC_CFG_RST      16'h0010
`define VTC_CFG3_RST     4'hf
`define VTC_OFF_SHIFT    11
`define VTC_GAIN_FRAC    23
`define VTC_HPF_SHIFT    10
`define VTC_CLK_NS       10
`define VTC_DR_LEAD_NS   6500
`define VTC_DR_LOW_NS    10000
`define VTC_SETTLE_MS    1024
`endif

// [rtl/vtc_pkg.sv]
// Types shared by the voltage and temperature channel datapath.
// Assumes nothing of its surroundings.
package vtc_pkg;
  typedef struct packed {
    logic [23:0] prim;
    logic [23:0] sec;
  } vtc_line_t;
  typedef struct packed {
    logic       valid;
    logic [1:0] line;
    logic [7:0] value;
  } vtc_off_t;
  typedef enum logic [1:0] {
    VTC_IDLE = 2'b00,
    VTC_LEAD = 2'b01,
    VTC_TAIL = 2'b11
  } vtc_rdy_state_t;
endpackage

// [test/vtc_remote_model.sv]
// Behavioural model of the four remote converters and their offset link.
// Assumes the bench pulses fire no more often than the datapath accepts.
`timescale 1ns/10ps
`default_nettype none
module vtc_remote_model #(
  parameter logic [3:0] NO_SECOND = 4'h0
) (
  // Clock and reset.
  input  wire logic               aclk,
  input  wire logic               aresetn,
  // Requests from the bench.
  input  wire logic               fire,
  input  wire logic [23:0]        v_in [8],
  input  wire logic [23:0]        t_in,
  input  wire logic               off_fire,
  input  wire logic [1:0]         off_line,
  input  wire logic [7:0]         off_val,
  // Select pins of the four lines.
  input  wire logic [3:0]         sel,
  // Towards the datapath.
  output var  logic               sample_valid,
  output var  vtc_pkg::vtc_line_t line_sample [4],
  output var  vtc_pkg::vtc_off_t  offset_load
);
  import vtc_pkg::*;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sample_valid <= 1'b0;
    end else begin
      sample_valid <= fire;
    end
  end
  // Between samples the lines invert every cycle, flipping between the last word and its inverse, so a
  // capture at the wrong edge shows up as a wrong result.
  always_ff @(posedge aclk) begin
    for (int i = 0; i < 4; i++) begin
      if (!aresetn) begin
        line_sample[i] <= '0;
      end else if (fire) begin
        line_sample[i].prim <= v_in[2*i];
        // A chip without a second input always returns its temperature.
        line_sample[i].sec <= (sel[i] && !NO_SECOND[i]) ?
                              v_in[2*i+1] : t_in;
      end else begin
        line_sample[i] <= ~line_sample[i];
      end
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      offset_load <= '0;
    end else if (off_fire) begin
      offset_load <= {1'b1, off_line, off_val};
    end else begin
      offset_load <= {1'b0, ~offset_load.line, ~offset_load.value};
    end
  end
endmodule
`default_nettype wire

// [test/tb_vtc_datapath.sv]
// Self-checking bench of the voltage and temperature channel datapath.
// Assumes the remote converter model drives the sample side.
`timescale 1ns/10ps
`default_nettype none
module tb_vtc_datapath;
  import vtc_pkg::*;
  typedef struct packed {logic [23:0] x; logic [23:0] g;} vtc_row_t;
  // Raw temperature code; the host turns it into degrees itself.
  localparam logic [23:0] T = 24'h100000;
  localparam vtc_row_t ROWS [8] = '{
    '{24'h100000, 24'h400000}, '{24'h100000, 24'hc00000},
    '{24'hf00000, 24'h400000}, '{24'h600000, 24'h400000},
    '{24'ha00000, 24'h400000}, '{24'h512d40, 24'h000000},
    '{24'h100000, 24'h200000}, '{T, 24'h800000}};
  logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_rready, fire, off_fire;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, off_val;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, off_line, rs;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic        s_axi_rvalid, sample_valid, shared_event_pin, irq_n;
  logic        phase_a_select_pin, phase_b_select_pin;
  logic        phase_c_select_pin, neutral_select_pin;
  logic [2:0]  zx_phase_level;
  logic [23:0] v_in [8];
  vtc_line_t   line_sample [4];
  vtc_off_t    offset_load;
  int          num_errors, n_compared, cyc, low_n, lead_n;
  vtc_datapath #(.SETTLE_CYCLES(1200)) vtc_datapath_inst (.*);
  vtc_remote_model #(.NO_SECOND(4'h8)) vtc_remote_model_inst (
    .aclk(aclk), .aresetn(aresetn), .fire(fire), .v_in(v_in), .t_in(T),
    .off_fire(off_fire), .off_line(off_line), .off_val(off_val),
    .sel({neutral_select_pin, phase_c_select_pin, phase_b_select_pin,
          phase_a_select_pin}),
    .sample_valid(sample_valid), .line_sample(line_sample),
    .offset_load(offset_load));
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t word %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t pin %b expected %b", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    if (num_errors == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      num_ers_timeout();
    end
  end
  task automatic num_ers_timeout();
    num_errors++;
    $display("ERROR %0t timeout", $time);
    tally_and_finish();
  endtask
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
                           output logic [1:0] r);
    bit ad, wd;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (!ad && s_axi_awready) begin
        s_axi_awvalid <= 1'b0;
        ad = 1'b1;
      end
      if (!wd && s_axi_wready) begin
        s_axi_wvalid <= 1'b0;
        wd = 1'b1;
      end
    end while (!(ad && wd));
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic axi_read(input logic [7:0] a, output logic [31:0] d,
                          output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    while (s_axi_rvalid !== 1'b1) @(posedge aclk);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  // Sends one sample set and times the ready pulse and the interrupt.
  task automatic do_sample();
    repeat (5) @(posedge aclk);
    fire <= 1'b1;
    @(posedge aclk);
    fire <= 1'b0;
    do @(posedge aclk); while (shared_event_pin !== 1'b0);
    low_n = 0;
    lead_n = -1;
    do begin
      @(posedge aclk);
      low_n++;
      if (lead_n < 0 && irq_n === 1'b0) lead_n = low_n;
    end while (shared_event_pin !== 1'b1);
  endtask
  function automatic logic [23:0] exp_gain(input logic [23:0] x,
                                           input logic [23:0] g);
    logic signed [49:0] p;
    p = $signed(x) + (($signed(x) * $signed(g)) >>> 23);
    if (p > 50'sh7fffff) return 24'h7fffff;
    if (p < -50'sh800000) return 24'h800000;
    return p[23:0];
  endfunction
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, fire, off_fire, off_line} = '0;
    {s_axi_awaddr, s_axi_araddr, off_val, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    zx_phase_level = 3'h0;
    foreach (v_in[i]) v_in[i] = ROWS[i].x;
    {num_errors, n_compared, cyc} = '0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    axi_read(8'h00, rd, rs);
    chk_word(rd, 32'h0000_0010);
    axi_read(8'h04, rd, rs);
    chk_word(rd, 32'h0000_000f);
    chk_bit(phase_a_select_pin & neutral_select_pin, 1'b1);
    chk_bit(shared_event_pin & irq_n, 1'b1);
    axi_write(8'h00, 32'h0, rs);
    axi_write(8'h0c, 32'h0002_0000, rs);
    for (int i = 0; i < 8; i++) begin
      axi_write(8'h10 + 8'(i * 4), {8'h0, ROWS[i].g}, rs);
      axi_read(8'h10 + 8'(i * 4), rd, rs);
      chk_word(rd, {4'h0, {4{ROWS[i].g[23]}}, ROWS[i].g});
    end
    do_sample();
    chk_word(low_n, 1000);
    chk_bit(lead_n >= 650 && lead_n <= 653, 1'b1);
    for (int i = 0; i < 8; i++) begin
      axi_read(8'h50 + 8'(i * 4), rd, rs);
      chk_word(rd, 32'(signed'(exp_gain(ROWS[i].x, ROWS[i].g))));
    end
    axi_read(8'h08, rd, rs);
    chk_word(rd & 32'h0002_0000, 32'h0002_0000);
    axi_write(8'h08, 32'h0002_0000, rs);
    repeat (3) @(posedge aclk);
    chk_bit(irq_n, 1'b1);
    // Line A goes to temperature; the first sample comes too early.
    axi_write(8'h04, 32'h0000_000e, rs);
    axi_write(8'h30, 32'h0040_0000, rs);
    axi_write(8'h0c, 32'h0, rs);
    @(posedge aclk);
    off_fire <= 1'b1;
    off_val <= 8'h10;
    @(posedge aclk);
    off_fire <= 1'b0;
    chk_bit(phase_a_select_pin, 1'b0);
    chk_bit(phase_b_select_pin, 1'b1);
    axi_read(8'h40, rd, rs);
    chk_word(rd, 32'h0000_0010);
    do_sample();
    chk_bit(lead_n < 0, 1'b1);
    axi_read(8'h70, rd, rs);
    chk_word(rd, 32'h0);
    do_sample();
    axi_read(8'h70, rd, rs);
    chk_word(rd, 32'h0018_c000);
    for (int m = 1; m < 4; m++) begin
      axi_write(8'h00, 32'(m), rs);
      zx_phase_level <= 3'(1 << (m - 1));
      repeat (3) @(posedge aclk);
      chk_bit(shared_event_pin, 1'b1);
      zx_phase_level <= ~3'(1 << (m - 1));
      repeat (3) @(posedge aclk);
      chk_bit(shared_event_pin, 1'b0);
    end
    axi_write(8'h80, 32'h1, rs);
    chk_word(rs, 2'b10);
    axi_write(8'h50, 32'h1, rs);
    chk_word(rs, 2'b10);
    axi_read(8'h80, rd, rs);
    chk_word({rd[29:0], rs}, 32'h2);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    chk_bit(phase_a_select_pin, 1'b1);
    axi_read(8'h00, rd, rs);
    chk_word(rd, 32'h0000_0010);
    tally_and_finish();
  end
endmodule
`default_nettype wire
